// ===== common/sck_pkg.sv
package sck_pkg;
    localparam int ADDR_W = 12;
    localparam int ROW_W = 11;
    localparam int BANK_SELECT_BIT = 11;
    localparam int AUTO_PRE_BIT = 10;
    localparam int PIN_W = 17;
    // Clock enable high, strobes high, address low
    localparam logic [16:0] PIN_RST = 17'h1F000;
    localparam int BL_LSB = 0;
    localparam int BL_W = 3;
    localparam logic [2:0] BL_FULL_PAGE = 3'h7;
    localparam logic [2:0] BL_MAX_FIXED = 3'h3;
    localparam logic [11:0] MODE_RST = 12'h000;
    localparam logic [10:0] REF_ROW_RST = 11'h000;
    localparam int TIMER_W = 8;
    localparam int BURST_W = 9;

    localparam int CLK_PERIOD_NS = 4;
    localparam int PRECHARGE_TIME_NS = 20;
    localparam int ROW_TO_COLUMN_DELAY_NS = 20;
    localparam int WRITE_RECOVERY_NS = 10;
    localparam int SR_RECOVERY_NS = 70;
    localparam int MODE_SET_DELAY_CLK = 2;

    localparam int PRECHARGE_CYC =
        (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_TO_COLUMN_CYC =
        (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_RECOVERY_PRECHARGE_CYC =
        (WRITE_RECOVERY_NS + PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int SR_RECOVERY_CYC =
        (SR_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MODE_SET_CYC = MODE_SET_DELAY_CLK;

    typedef enum logic [3:0] {
        BK_IDLE, BK_ROW_OPENING, BK_ACTIVE, BK_READ, BK_WRITE,
        BK_READ_AP, BK_WRITE_AP, BK_WR_RECOVERY_AP, BK_PRECHARGE
    } sck_bank_e;

    typedef enum logic [2:0] {
        DEV_NORMAL, DEV_MODE_SET, DEV_REFRESH, DEV_SELF_REFRESH,
        DEV_SR_RECOVERY, DEV_POWER_DOWN
    } sck_dev_e;
endpackage

// ===== hdl/sck_bank.sv
`timescale 1ns/10ps
module sck_bank #(
    parameter int RCD_CYC = sck_pkg::ROW_TO_COLUMN_CYC,
    parameter int RP_CYC = sck_pkg::PRECHARGE_CYC,
    parameter int DAL_CYC = sck_pkg::WRITE_RECOVERY_PRECHARGE_CYC
) (
    input logic sys_clk_in,
    input logic sys_rst_in,
    input logic stall_in,
    input logic activate_in,
    input logic read_in,
    input logic write_in,
    input logic auto_pre_in,
    input logic precharge_in,
    input logic stop_in,
    input logic [sck_pkg::BURST_W-1:0] burst_len_in,
    output sck_pkg::sck_bank_e state_out,
    output logic idle_out
);
    localparam int TW = sck_pkg::TIMER_W;
    localparam int BW = sck_pkg::BURST_W;
    localparam logic [TW-1:0] RCD_LOAD = TW'(RCD_CYC - 1);
    localparam logic [TW-1:0] RP_LOAD = TW'(RP_CYC - 1);
    localparam logic [TW-1:0] DAL_LOAD = TW'(DAL_CYC - 1);

    sck_pkg::sck_bank_e state, next_state, col_state;
    logic [TW-1:0] timer, next_timer;
    logic [BW-1:0] burst, next_burst;

    wire timer_done = (timer == '0);
    // Zero length means full page: a stop, precharge or new column command ends it; with auto precharge nothing does
    wire burst_done = (burst_len_in != '0) && (burst == '0);
    wire [BW-1:0] burst_load = burst_len_in - 1'b1;
    wire column_cmd = read_in | write_in;

    assign col_state = read_in ?
        (auto_pre_in ? sck_pkg::BK_READ_AP : sck_pkg::BK_READ) :
        (auto_pre_in ? sck_pkg::BK_WRITE_AP : sck_pkg::BK_WRITE);

    always_comb begin
        next_state = state;
        next_timer = timer - 1'b1;
        next_burst = burst - 1'b1;
        if (stall_in) begin
            next_timer = timer; // see R20
            next_burst = burst;
        end else begin
            // Commands not valid in a state are simply dropped, see R10
            case (state)
                sck_pkg::BK_IDLE: begin
                    if (activate_in) begin
                        next_state = sck_pkg::BK_ROW_OPENING;
                        next_timer = RCD_LOAD;
                    end
                end
                sck_pkg::BK_ROW_OPENING: begin
                    if (timer_done) begin
                        next_state = sck_pkg::BK_ACTIVE;
                    end
                end
                sck_pkg::BK_ACTIVE, sck_pkg::BK_READ,
                sck_pkg::BK_WRITE: begin
                    if (column_cmd) begin
                        next_state = col_state;
                        next_burst = burst_load;
                    end else if (precharge_in) begin
                        next_state = sck_pkg::BK_PRECHARGE;
                        next_timer = RP_LOAD;
                    end else if (state != sck_pkg::BK_ACTIVE &&
                                 (stop_in || burst_done)) begin
                        next_state = sck_pkg::BK_ACTIVE;
                    end
                end
                sck_pkg::BK_READ_AP: begin
                    if (burst_done) begin
                        next_state = sck_pkg::BK_PRECHARGE; // see R15
                        next_timer = RP_LOAD;
                    end
                end
                sck_pkg::BK_WRITE_AP: begin
                    if (burst_done) begin
                        next_state = sck_pkg::BK_WR_RECOVERY_AP; // see R15
                        next_timer = DAL_LOAD;
                    end
                end
                sck_pkg::BK_WR_RECOVERY_AP, sck_pkg::BK_PRECHARGE: begin
                    if (timer_done) begin
                        next_state = sck_pkg::BK_IDLE; // see R02
                    end
                end
                default: begin
                    next_state = sck_pkg::BK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state <= sck_pkg::BK_IDLE;
            timer <= '0;
            burst <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            burst <= next_burst;
        end
    end

    assign state_out = state;
    assign idle_out = (state == sck_pkg::BK_IDLE);

    a_suspend_freeze: assert property (@(posedge sys_clk_in) // see R20
        disable iff (sys_rst_in) stall_in |=> $stable(state))
        else $error("bank state moved during clock suspend");
    a_ap_precharge: assert property (@(posedge sys_clk_in) // see R15
        disable iff (sys_rst_in)
        (state == sck_pkg::BK_READ_AP && burst_done && !stall_in)
        |=> state == sck_pkg::BK_PRECHARGE)
        else $error("auto precharge did not start after burst");
    a_dal_idle: assert property (@(posedge sys_clk_in) // see R02
        disable iff (sys_rst_in)
        (state == sck_pkg::BK_WR_RECOVERY_AP && !timer_done)
        |=> state == sck_pkg::BK_WR_RECOVERY_AP)
        else $error("write recovery left before its interval");
endmodule // sck_bank

// ===== hdl/sck_sdram_cmd.sv
// Behaviour
// R01 - All command, address and control pins are sampled on the rising edge.
// R02 - Write recovery with auto precharge ignores waits, idles after interval.
// R03 - Controller issues conditional commands only if the selected bank allows.
// R04 - Auto refresh treats waits as no-op and idles after precharge time.
// R05 - After mode set only waits allowed; idle after mode set delay.
// R06 - Controller idles both banks before mode set or any refresh.
// R07 - Mode set loads the whole twelve-bit address into the mode register.
// R08 - Auto refresh uses an internal row counter, ignoring address pins.
// R09 - Self refresh ignores every input except clock enable.
// R10 - Controller activates idle banks only, reads and writes active ones.
// R11 - Burst stop is honoured only with full-page burst length.
// R12 - Both banks idle and clock enable low enters power down.
// R13 - Refresh with clock enable falling and banks idle enters self refresh.
// R14 - Controller never precharges before the minimum row-active time.
// R15 - Auto precharge starts as soon as the burst completes.
// R16 - Controller waits the row-to-column delay after activate.
// R17 - Clock enable rising with a wait command starts self refresh recovery.
// R18 - Clock enable falling during recovery enters power down next cycle.
// R19 - Power down ends when clock enable rises, holds while low.
// R20 - Outside all-idle, clock enable low suspends the clock next cycle.
// R21 - All-idle command decode: activate/precharge, auto refresh, mode set.
// R22 - A rising clock enable reactivates the inputs without a clock edge. This core sees the rise only on the sampled clock edge.
// R23 - Controller waits two cycles after mode set before another command.
// R24 - Power-on: clock enable high, precharge, two refreshes, mode set.
// R25 - Controller fills every wait with deselect or no-operation.
`timescale 1ns/10ps
module sck_sdram_cmd #(
    parameter int RCD_CYC = sck_pkg::ROW_TO_COLUMN_CYC,
    parameter int RP_CYC = sck_pkg::PRECHARGE_CYC,
    parameter int DAL_CYC = sck_pkg::WRITE_RECOVERY_PRECHARGE_CYC,
    parameter int MCD_CYC = sck_pkg::MODE_SET_CYC,
    parameter int SRR_CYC = sck_pkg::SR_RECOVERY_CYC
) (
    input logic sys_clk_in,
    input logic sys_rst_in,
    input logic cke_in,
    input logic cs_n_in,
    input logic ras_n_in,
    input logic cas_n_in,
    input logic we_n_in,
    input logic [sck_pkg::ADDR_W-1:0] addr_in,
    output sck_pkg::sck_dev_e dev_state_out,
    output sck_pkg::sck_bank_e bank0_state_out,
    output sck_pkg::sck_bank_e bank1_state_out,
    output logic [sck_pkg::ADDR_W-1:0] mode_reg_out,
    output logic [sck_pkg::ROW_W-1:0] refresh_row_out,
    output logic refresh_pulse_out,
    output logic power_down_out,
    output logic self_refresh_out,
    output logic clock_suspend_out,
    output logic illegal_cmd_out
);
    localparam int TW = sck_pkg::TIMER_W;
    localparam int BW = sck_pkg::BURST_W;
    localparam int PW = sck_pkg::PIN_W;
    localparam int AW = sck_pkg::ADDR_W;
    localparam logic [TW-1:0] RP_LOAD = TW'(RP_CYC - 1);
    localparam logic [TW-1:0] MCD_LOAD = TW'(MCD_CYC - 1);
    localparam logic [TW-1:0] SRR_LOAD = TW'(SRR_CYC - 1);

    // Pin capture
    logic [PW-1:0] pin_meta;
    logic [PW-1:0] pin_sync;
    logic cke_prev;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            // Idle pin levels, so no false clock-enable edge after reset
            pin_meta <= sck_pkg::PIN_RST;
            pin_sync <= sck_pkg::PIN_RST;
            cke_prev <= 1'b1;
        end else begin
            pin_meta <= {cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
                         addr_in}; // see R01
            pin_sync <= pin_meta;
            cke_prev <= pin_sync[PW-1];
        end
    end

    // Wake-up is seen on the sampled edge only; this core has no
    // path that acts between edges, see R22
    wire cke_now = pin_sync[PW-1];
    wire cs_n = pin_sync[PW-2];
    wire ras_n = pin_sync[PW-3];
    wire cas_n = pin_sync[PW-4];
    wire we_n = pin_sync[PW-5];
    wire [AW-1:0] addr = pin_sync[AW-1:0];

    // Command decode, see R21
    wire deselect_cmd = cs_n;
    wire nop_cmd = !cs_n && ras_n && cas_n && we_n;
    wire burst_stop_cmd = !cs_n && ras_n && cas_n && !we_n;
    wire read_cmd = !cs_n && ras_n && !cas_n && we_n;
    wire column_write_cmd = !cs_n && ras_n && !cas_n && !we_n;
    wire row_activate_cmd = !cs_n && !ras_n && cas_n && we_n;
    wire precharge_cmd = !cs_n && !ras_n && cas_n && !we_n;
    wire refresh_cmd = !cs_n && !ras_n && !cas_n && we_n;
    wire mode_register_set_cmd = !cs_n && !ras_n && !cas_n && !we_n;
    wire wait_cmd = deselect_cmd || nop_cmd || burst_stop_cmd;
    wire wake_cmd = cs_n || (ras_n && cas_n);

    wire bank_select_bit = addr[sck_pkg::BANK_SELECT_BIT];
    wire auto_pre = addr[sck_pkg::AUTO_PRE_BIT];
    wire precharge_all_cmd = precharge_cmd && auto_pre;

    // Mode register and derived burst length
    logic [AW-1:0] mode_reg;
    wire [sck_pkg::BL_W-1:0] bl_code =
        mode_reg[sck_pkg::BL_LSB +: sck_pkg::BL_W];
    wire full_page = (bl_code == sck_pkg::BL_FULL_PAGE);
    // Reserved length codes fall back to single beats
    wire [BW-1:0] burst_len = full_page ? '0 :
        (bl_code <= sck_pkg::BL_MAX_FIXED) ?
        BW'(1) << bl_code : BW'(1);

    // Device level state
    sck_pkg::sck_dev_e dev, next_dev;
    logic [TW-1:0] timer, next_timer;
    logic [1:0] bank_idle;
    sck_pkg::sck_bank_e bank_state [2];

    wire normal = (dev == sck_pkg::DEV_NORMAL);
    wire banks_idle = &bank_idle;
    wire all_idle = normal && banks_idle;
    wire cmd_live = normal && cke_prev;
    wire suspend = normal && !banks_idle && !cke_prev; // see R20
    wire timer_done = (timer == '0);

    wire take_mrs = all_idle && cke_prev && mode_register_set_cmd;
    wire take_refresh = all_idle && cke_prev && cke_now && refresh_cmd;
    wire take_self = all_idle && cke_prev && !cke_now && refresh_cmd;
    wire enter_pd = all_idle && !cke_prev; // see R12
    wire sr_exit = !cke_prev && cke_now && wake_cmd; // see R17
    wire srr_to_pd = cke_prev && !cke_now && wake_cmd; // see R18
    wire pd_exit = !cke_prev && cke_now; // see R19

    // Per-bank command steering; a bank ignores what its state forbids
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_bank
            wire hit = (bank_select_bit == 1'(gi));
            wire act_b = cmd_live && row_activate_cmd && hit;
            wire rd_b = cmd_live && read_cmd && hit;
            wire wr_b = cmd_live && column_write_cmd && hit;
            wire pre_b = cmd_live && (precharge_all_cmd ||
                                      (precharge_cmd && hit));
            wire stop_b = cmd_live && burst_stop_cmd && full_page; // see R11

            sck_bank #(
                .RCD_CYC(RCD_CYC),
                .RP_CYC(RP_CYC),
                .DAL_CYC(DAL_CYC)
            ) u_bank (
                .sys_clk_in(sys_clk_in),
                .sys_rst_in(sys_rst_in),
                .stall_in(suspend),
                .activate_in(act_b),
                .read_in(rd_b),
                .write_in(wr_b),
                .auto_pre_in(auto_pre),
                .precharge_in(pre_b),
                .stop_in(stop_b),
                .burst_len_in(burst_len),
                .state_out(bank_state[gi]),
                .idle_out(bank_idle[gi])
            );
        end
    endgenerate

    always_comb begin
        next_dev = dev;
        next_timer = timer;
        case (dev)
            sck_pkg::DEV_NORMAL: begin
                if (take_mrs) begin
                    next_dev = sck_pkg::DEV_MODE_SET;
                    next_timer = MCD_LOAD;
                end else if (take_refresh) begin
                    next_dev = sck_pkg::DEV_REFRESH;
                    next_timer = RP_LOAD;
                end else if (take_self) begin
                    next_dev = sck_pkg::DEV_SELF_REFRESH; // see R13
                end else if (enter_pd) begin
                    next_dev = sck_pkg::DEV_POWER_DOWN;
                end
            end
            sck_pkg::DEV_MODE_SET, sck_pkg::DEV_REFRESH: begin
                // Internal operations run on even if the clock is held
                if (timer_done) begin
                    next_dev = sck_pkg::DEV_NORMAL; // see R04 R05
                end else begin
                    next_timer = timer - 1'b1;
                end
            end
            sck_pkg::DEV_SELF_REFRESH: begin // see R09
                if (sr_exit) begin
                    next_dev = sck_pkg::DEV_SR_RECOVERY;
                    next_timer = SRR_LOAD;
                end
            end
            sck_pkg::DEV_SR_RECOVERY: begin
                if (srr_to_pd) begin
                    next_dev = sck_pkg::DEV_POWER_DOWN;
                end else if (cke_prev && timer_done) begin
                    next_dev = sck_pkg::DEV_NORMAL;
                end else if (cke_prev) begin
                    next_timer = timer - 1'b1;
                end
            end
            sck_pkg::DEV_POWER_DOWN: begin
                if (pd_exit) begin
                    next_dev = sck_pkg::DEV_NORMAL;
                end
            end
            default: begin
                next_dev = sck_pkg::DEV_NORMAL;
            end
        endcase
    end

    // Commands outside the allowed set are flagged, never acted on
    wire bad_wait = (dev == sck_pkg::DEV_MODE_SET ||
                     dev == sck_pkg::DEV_REFRESH) && !wait_cmd;
    wire bad_sr = (dev == sck_pkg::DEV_SELF_REFRESH) &&
                  !cke_prev && cke_now && !wake_cmd;
    wire bad_srr = (dev == sck_pkg::DEV_SR_RECOVERY) &&
                   cke_prev && !wake_cmd;
    wire illegal_now = bad_wait || bad_sr || bad_srr;
    wire refresh_go = take_refresh || take_self;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            dev <= sck_pkg::DEV_NORMAL;
            timer <= '0;
        end else begin
            dev <= next_dev;
            timer <= next_timer;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            mode_reg <= sck_pkg::MODE_RST;
        end else if (take_mrs) begin
            mode_reg <= addr; // see R07
        end
    end

    logic [sck_pkg::ROW_W-1:0] refresh_row;
    logic refresh_pulse;
    logic illegal_cmd;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            refresh_row <= sck_pkg::REF_ROW_RST;
            refresh_pulse <= 1'b0;
            illegal_cmd <= 1'b0;
        end else begin
            if (refresh_go) begin
                refresh_row <= refresh_row + 1'b1; // see R08
            end
            refresh_pulse <= refresh_go;
            illegal_cmd <= illegal_now;
        end
    end

    assign dev_state_out = dev;
    assign bank0_state_out = bank_state[0];
    assign bank1_state_out = bank_state[1];
    assign mode_reg_out = mode_reg;
    assign refresh_row_out = refresh_row;
    assign refresh_pulse_out = refresh_pulse;
    assign power_down_out = (dev == sck_pkg::DEV_POWER_DOWN);
    assign self_refresh_out = (dev == sck_pkg::DEV_SELF_REFRESH);
    assign clock_suspend_out = suspend ||
        (dev == sck_pkg::DEV_SR_RECOVERY && !cke_prev);
    assign illegal_cmd_out = illegal_cmd;

    // Busy windows sized for the default timing counts
    sequence seq_mode_busy;
        (dev == sck_pkg::DEV_MODE_SET)[*2] ##1
        (dev == sck_pkg::DEV_NORMAL);
    endsequence
    sequence seq_refresh_busy;
        (dev == sck_pkg::DEV_REFRESH)[*5] ##1
        (dev == sck_pkg::DEV_NORMAL);
    endsequence

    a_mode_load: assert property (@(posedge sys_clk_in) // see R07
        disable iff (sys_rst_in) take_mrs |=> mode_reg == $past(addr))
        else $error("mode register did not take the address");
    a_mode_wait: assert property (@(posedge sys_clk_in) // see R05
        disable iff (sys_rst_in) take_mrs |=> seq_mode_busy)
        else $error("mode set delay not kept");
    a_refresh_wait: assert property (@(posedge sys_clk_in) // see R04
        disable iff (sys_rst_in) take_refresh |=> seq_refresh_busy)
        else $error("refresh did not idle after precharge time");
    a_refresh_row: assert property (@(posedge sys_clk_in) // see R08
        disable iff (sys_rst_in)
        refresh_go |=> refresh_row == $past(refresh_row) + 1'b1)
        else $error("internal refresh row did not advance");
    a_self_entry: assert property (@(posedge sys_clk_in) // see R13
        disable iff (sys_rst_in)
        take_self |=> self_refresh_out && refresh_pulse_out)
        else $error("self refresh not entered");
    a_self_ignore: assert property (@(posedge sys_clk_in) // see R09
        disable iff (sys_rst_in)
        (dev == sck_pkg::DEV_SELF_REFRESH && !sr_exit)
        |=> self_refresh_out && $stable(mode_reg) && banks_idle)
        else $error("self refresh reacted to an input");
    a_pd_entry: assert property (@(posedge sys_clk_in) // see R12
        disable iff (sys_rst_in) enter_pd |=> power_down_out)
        else $error("power down not entered with banks idle");
    a_pd_hold: assert property (@(posedge sys_clk_in) // see R19
        disable iff (sys_rst_in)
        (power_down_out && !cke_now) |=> power_down_out ##0 !cke_prev)
        else $error("power down left while clock enable low");
    a_pd_exit: assert property (@(posedge sys_clk_in) // see R19
        disable iff (sys_rst_in)
        (power_down_out && pd_exit) |=> dev == sck_pkg::DEV_NORMAL)
        else $error("power down did not end on clock enable rise");
    a_srr_to_pd: assert property (@(posedge sys_clk_in) // see R18
        disable iff (sys_rst_in)
        (dev == sck_pkg::DEV_SR_RECOVERY && srr_to_pd)
        |=> power_down_out)
        else $error("recovery did not fall into power down");
    a_sr_exit: assert property (@(posedge sys_clk_in) // see R17
        disable iff (sys_rst_in)
        (self_refresh_out && sr_exit)
        |=> dev == sck_pkg::DEV_SR_RECOVERY)
        else $error("self refresh exit not taken");
endmodule // sck_sdram_cmd

// ===== test/sck_ctl_model.sv
`timescale 1ns/10ps
module sck_ctl_model (
    input wire logic clk_in,
    output logic cke_out,
    output logic cs_n_out,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic [11:0] addr_out
);
    initial begin
        cke_out = 1'b1;
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
        addr_out = 12'h000;
    end
    // Called at a falling edge; the command stands for exactly one edge
    task automatic cmd(input logic [3:0] c, input logic [11:0] a);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = c;
        addr_out = a;
        @(negedge clk_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'h7;
        addr_out = ~a; // Released lines must not keep the last value
    endtask
    task automatic set_cke(input logic v);
        cke_out = v;
    endtask
endmodule // sck_ctl_model

// ===== test/test_sck_sdram_cmd.sv
`timescale 1ns/10ps
module test_sck_sdram_cmd;
    localparam logic [3:0] C_MRS = 4'h0, C_REF = 4'h1, C_PRE = 4'h2;
    localparam logic [3:0] C_ACT = 4'h3, C_RD = 4'h5;
    localparam logic [3:0] C_WR = 4'h4, C_BST = 4'h6;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cke, cs_n, ras_n, cas_n, we_n, rpulse, pd, sr, susp, ill;
    logic [11:0] addr, mode;
    logic [10:0] row;
    logic [10:0] exp_row = 11'h000;
    sck_pkg::sck_dev_e dev;
    sck_pkg::sck_bank_e bk0, bk1;
    int fails = 0;
    int n_checks = 0;
    sck_ctl_model ctl_u (.clk_in(clk), .cke_out(cke), .cs_n_out(cs_n),
        .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
        .addr_out(addr));
    sck_sdram_cmd dut_u (.sys_clk_in(clk), .sys_rst_in(rst), .cke_in(cke),
        .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
        .addr_in(addr), .dev_state_out(dev), .bank0_state_out(bk0),
        .bank1_state_out(bk1), .mode_reg_out(mode), .refresh_row_out(row),
        .refresh_pulse_out(rpulse), .power_down_out(pd),
        .self_refresh_out(sr), .clock_suspend_out(susp),
        .illegal_cmd_out(ill));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic stop_test();
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    function automatic logic probe(input int s);
        case (s)
            0: return dev === sck_pkg::DEV_POWER_DOWN;
            1: return dev === sck_pkg::DEV_NORMAL;
            2: return dev === sck_pkg::DEV_SELF_REFRESH;
            3: return dev === sck_pkg::DEV_SR_RECOVERY;
            4: return bk1 === sck_pkg::BK_PRECHARGE;
            5: return bk1 === sck_pkg::BK_IDLE;
            6: return bk0 === sck_pkg::BK_ACTIVE;
            7: return susp === 1'b1;
            8: return susp === 1'b0;
            10: return dev === sck_pkg::DEV_MODE_SET;
            11: return dev === sck_pkg::DEV_REFRESH;
            12: return bk1 === sck_pkg::BK_ROW_OPENING;
            13: return bk1 === sck_pkg::BK_ACTIVE;
            14: return bk1 === sck_pkg::BK_READ_AP;
            15: return bk0 === sck_pkg::BK_WR_RECOVERY_AP;
            default: return bk0 === sck_pkg::BK_IDLE;
        endcase
    endfunction
    // Bounded poll; running out ends the run at once
    task automatic await(input int s, input int n, output int k);
        for (k = 0; k < n && !probe(s); k++)
            tick(1);
        chk(probe(s), "state not reached in time");
        if (!probe(s))
            stop_test();
    endtask
    task automatic t_mode_set();
        ctl_u.cmd(C_MRS, 12'hA48);
        tick(1);
        ctl_u.cmd(C_ACT, 12'h000);
        tick(1);
        chk(probe(10), "no mode set");
        chk(mode === 12'hA48, "mode register");
        tick(1);
        chk(ill === 1'b1, "command in mode set not flagged");
        chk(probe(1) && probe(9), "mode set exit");
    endtask
    task automatic t_refresh();
        ctl_u.cmd(C_REF, {1'b1, ~exp_row});
        exp_row++;
        tick(1);
        ctl_u.cmd(C_ACT, 12'h000);
        chk(probe(11) && rpulse === 1'b1, "refresh start");
        chk(row === exp_row, "refresh row");
        tick(2);
        chk(ill === 1'b1, "command in refresh not flagged");
        tick(3);
        chk(probe(1) && probe(9), "refresh exit");
    endtask
    task automatic t_power_down();
        int k;
        ctl_u.set_cke(1'b0);
        await(0, 8, k);
        ctl_u.cmd(C_ACT, 12'h000);
        tick(8);
        chk(pd === 1'b1 && probe(9), "power down not held");
        ctl_u.set_cke(1'b1);
        await(1, 8, k);
    endtask
    task automatic t_self_refresh();
        int k;
        ctl_u.set_cke(1'b0);
        ctl_u.cmd(C_REF, 12'h000);
        exp_row++;
        await(2, 8, k);
        chk(row === exp_row && sr === 1'b1, "self refresh entry");
        ctl_u.cmd(C_MRS, 12'h3FF);
        tick(6);
        chk(mode === 12'hA48 && ill === 1'b0, "input seen");
        ctl_u.set_cke(1'b1);
        await(3, 8, k);
        await(1, 40, k);
        chk(k >= sck_pkg::SR_RECOVERY_CYC - 2, "short recovery");
    endtask
    task automatic t_bank();
        int k;
        ctl_u.cmd(C_ACT, 12'h805);
        tick(3);
        chk(probe(12) && probe(9), "activate bank select");
        tick(5);
        chk(probe(13), "row not active");
        ctl_u.cmd(C_RD, 12'hC00);
        tick(2);
        chk(probe(14), "read with precharge");
        await(4, 6, k);
        await(5, 8, k);
    endtask
    task automatic t_write_ap();
        int k;
        ctl_u.cmd(C_ACT, 12'h000);
        await(6, 10, k);
        ctl_u.cmd(C_WR, 12'h400);
        await(15, 6, k);
        ctl_u.cmd(C_BST, 12'h000);
        tick(4);
        chk(probe(15), "recovery cut short");
        await(9, 8, k);
    endtask
    task automatic t_suspend();
        int k;
        ctl_u.cmd(C_ACT, 12'h000);
        await(6, 10, k);
        ctl_u.set_cke(1'b0);
        await(7, 6, k);
        tick(4);
        chk(probe(6) && probe(1), "suspend lost bank");
        ctl_u.set_cke(1'b1);
        await(8, 6, k);
        ctl_u.cmd(C_PRE, 12'h400);
        await(9, 10, k);
    endtask
    initial begin
        tick(6);
        rst = 1'b0;
        tick(12);
        ctl_u.cmd(C_PRE, 12'h400);
        t_refresh();
        t_refresh();
        t_mode_set();
        t_power_down();
        t_self_refresh();
        t_bank();
        t_write_ap();
        t_suspend();
        stop_test();
    end
endmodule // test_sck_sdram_cmd
